/* pkg/scan_pacer_defines.vh */
// Constants shared by the analog input scan pacer design files.
// What this block does
// [R1] Route active channels through one mux to converter
// [R2] Static input picks eight differential or sixteen single-ended
// [R3] Results are left-justified offset binary, both polarities
// [R4] Digital outputs select the expansion channel
// [R5] Host keeps backplane channels single-ended
// [R6] Paced mode after reset; burst only by software
// [R7] Paced: one conversion per pacer pulse, advance
// [R8] Burst: each pacer pulse scans one to sixteen
// [R9] Burst conversions spaced by burst clock
// [R10] Burst clock programmable 3.94 kHz to 100 kHz
// [R11] Host keeps pacer below burst rate per channel
// [R12] Host limits conversion rate by gain
// [R13] Gain code selects amplification
// [R14] Internal pacer: two cascaded counters on timebase
// [R15] At most one conversion every 10 microseconds
// [R16] External source: convert on each rising edge
// [R17] External pacer stays below converter maximum
// [R18] Idle pacer pulses still pace other events
// [R19] Software source converts only on start requests
// [R20] Gate holds off pacer pulses until input high
// [R21] No overlapping conversion on early pulse
// [R22] Result comes with channel and valid strobe
`ifndef SCAN_PACER_DEFINES_VH
`define SCAN_PACER_DEFINES_VH

`define CLK_HZ         40000000
`define CLK_PER_US     40
`define CONV_TIME_NS   10000
`define CONV_CYC       ((`CONV_TIME_NS * `CLK_PER_US) / 1000)
`define BURST_MAX_HZ   100000
`define BURST_MIN_HZ   3940
`define BURST_DIV_MIN  (`CLK_HZ / `BURST_MAX_HZ)
`define BURST_DIV_MAX  (`CLK_HZ / `BURST_MIN_HZ)
`define TB_1MHZ_DIV    40
`define TB_10MHZ_DIV   4
`define TB_1MHZ_TOP    6'h27
`define TB_10MHZ_TOP   6'h03
`define CONV_LAST      16'h018f
`define BDIV_MIN       16'h0190
`define BDIV_MAX       16'h27a8

`define REG_CTRL       3'h0
`define REG_SCAN       3'h1
`define REG_PACER      3'h2
`define REG_BURST      3'h3
`define REG_START      3'h4
`define REG_STATUS     3'h5
`define REG_DATA       3'h6
`define REG_DOUT       3'h7

`define SRC_SW         2'h0
`define SRC_INT        2'h1
`define SRC_EXT        2'h2

`define CTRL_SRC_LO    0
`define CTRL_SRC_HI    1
`define CTRL_BURST     2
`define CTRL_GATE      3
`define CTRL_EN        4
`define CTRL_RST       32'h00000000
`define SCAN_FIRST_LO  0
`define SCAN_FIRST_HI  3
`define SCAN_LAST_LO   4
`define SCAN_LAST_HI   7
`define SCAN_GAIN_LO   8
`define SCAN_GAIN_HI   9
`define SCAN_RST       32'h00000000
`define PACER_RST      32'h00020002
`define BURST_RST      32'h00000190
`define DOUT_RST       32'h00000000

`endif

/* rtl/analog_input_scan_pacer.v */
// Scan sequencer with Wishbone registers for one sampling converter.
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "scan_pacer_defines.vh"
module analog_input_scan_pacer (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [4:2]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    input  wire        diff_mode_i,
    input  wire        tb_10mhz_i,
    input  wire        ext_pacer_gate_input_i,
    input  wire [11:0] adc_data_i,
    output reg         adc_convert_o,
    output reg  [3:0]  mux_chan_o,
    output reg  [1:0]  gain_o,
    output reg  [3:0]  exp_sel_o,
    output reg  [15:0] result_o,
    output reg  [3:0]  result_chan_o,
    output reg         result_valid_o,
    output reg         pacer_event_o
);
    localparam ST_IDLE = 3'b001;
    localparam ST_CONV = 3'b010;
    localparam ST_GAP  = 3'b100;

    reg  [31:0] ctrl;
    reg  [31:0] scan;
    reg  [31:0] pacer;
    reg  [31:0] burst;
    reg  [31:0] dout;
    reg  [2:0]  state;
    reg  [2:0]  next_state;
    reg  [3:0]  chan;
    reg  [3:0]  next_chan;
    reg  [15:0] conv_cnt;
    reg  [15:0] gap_cnt;
    reg         ext_d;
    reg         sw_start;
    reg         overrun;
    reg  [31:0] wdata;
    reg  [31:0] rdata;

    wire [14:0] pins_s;
    wire        diff_s;
    wire        tb_s;
    wire        ext_s;
    wire [11:0] adc_s;
    wire        pacer_tick;
    wire [1:0]  src;
    wire        burst_mode;
    wire        enabled;
    wire        gate_open;
    wire        int_trig;
    wire        ext_trig;
    wire        trig;
    wire        conv_end;
    wire        gap_end;
    wire [3:0]  first_ch;
    wire [3:0]  last_ch;
    wire [3:0]  ch_mask;
    wire        wr;
    wire        rd;
    wire [31:0] wmask;
    wire [15:0] bdiv_req;
    wire [15:0] bdiv;

    // Every front-end pin passes two flip-flops before any logic looks at it.
    sync2 #(
        .W (15)
    ) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({diff_mode_i, tb_10mhz_i, ext_pacer_gate_input_i,
                 adc_data_i}),
        .q_o   (pins_s)
    );

    assign diff_s = pins_s[14];
    assign tb_s   = pins_s[13];
    assign ext_s  = pins_s[12];
    assign adc_s  = pins_s[11:0];

    pacer_counters u_pacer (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tb_10mhz_i (tb_s),
        .div1_i     (pacer[15:0]),
        .div2_i     (pacer[31:16]),
        .tick_o     (pacer_tick)
    );

    assign src        = ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO];
    assign burst_mode = ctrl[`CTRL_BURST];
    assign enabled    = ctrl[`CTRL_EN];
    assign first_ch   = scan[`SCAN_FIRST_HI:`SCAN_FIRST_LO];
    assign last_ch    = scan[`SCAN_LAST_HI:`SCAN_LAST_LO];

    // Differential wiring has only eight inputs, so bit 3 is forced low.
    assign ch_mask = diff_s ? 4'h7 : 4'hf; // [R2]

    // The gate shares the pacer pin and only holds off internal pulses.
    assign gate_open = !ctrl[`CTRL_GATE] || ext_s; // [R20]
    assign int_trig  = enabled && (src == `SRC_INT) && pacer_tick
                       && gate_open; // [R14] [R20]
    assign ext_trig  = enabled && (src == `SRC_EXT)
                       && ext_s && !ext_d; // [R16]
    assign trig      = int_trig || ext_trig ||
                       (sw_start && (src == `SRC_SW)); // [R19]

    assign conv_end = (state == ST_CONV) &&
                      (conv_cnt == `CONV_LAST); // [R15]
    assign gap_end  = (gap_cnt >= bdiv - 16'h0001);

    // Burst spacing stays inside 3.94 kHz .. 100 kHz whatever is written.
    assign bdiv_req = burst[15:0];
    assign bdiv = (bdiv_req < `BDIV_MIN) ? `BDIV_MIN :
                  (bdiv_req > `BDIV_MAX) ? `BDIV_MAX :
                  bdiv_req; // [R10]

    // Writes land on the edge where the master sees ack.
    assign wr    = cyc_i && stb_i && we_i && ack_o;
    assign rd    = cyc_i && stb_i && !ack_o;
    assign wmask = {{8{sel_i[3]}}, {8{sel_i[2]}},
                    {8{sel_i[1]}}, {8{sel_i[0]}}};

    always @* begin
        next_state = state;
        next_chan  = chan;
        case (state)
            ST_IDLE: begin
                if (trig) begin
                    next_state = ST_CONV;
                    if (burst_mode)
                        next_chan = first_ch & ch_mask; // [R8]
                end
            end
            ST_CONV: begin
                if (conv_end) begin
                    if (burst_mode && chan != (last_ch & ch_mask)) begin
                        next_state = ST_GAP; // [R9]
                        next_chan  = (chan + 4'h1) & ch_mask;
                    end else begin
                        next_state = ST_IDLE;
                        if (chan == (last_ch & ch_mask))
                            next_chan = first_ch & ch_mask; // [R7]
                        else
                            next_chan = (chan + 4'h1) & ch_mask; // [R7]
                    end
                end
            end
            ST_GAP: begin
                if (gap_end)
                    next_state = ST_CONV; // [R9]
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @* begin
        case (adr_i)
            `REG_CTRL:   rdata = ctrl;
            `REG_SCAN:   rdata = scan;
            `REG_PACER:  rdata = pacer;
            `REG_BURST:  rdata = {16'h0000, bdiv};
            `REG_STATUS: rdata = {24'h000000, overrun, state != ST_IDLE,
                                  diff_s, tb_s, chan};
            `REG_DATA:   rdata = {12'h000, result_chan_o, result_o};
            `REG_DOUT:   rdata = dout;
            default:     rdata = 32'h00000000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (rd)
                dat_o <= we_i ? 32'h00000000 : rdata;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= `CTRL_RST; // [R6]
            scan     <= `SCAN_RST;
            pacer    <= `PACER_RST;
            burst    <= `BURST_RST;
            dout     <= `DOUT_RST;
            sw_start <= 1'b0;
        end else begin
            sw_start <= 1'b0;
            if (wr) begin
                case (adr_i)
                    `REG_CTRL:  ctrl  <= (ctrl & ~wmask) | (dat_i & wmask);
                    `REG_SCAN:  scan  <= (scan & ~wmask) | (dat_i & wmask);
                    `REG_PACER: pacer <= (pacer & ~wmask) | (dat_i & wmask);
                    `REG_BURST: burst <= (burst & ~wmask) | (dat_i & wmask);
                    `REG_DOUT:  dout  <= (dout & ~wmask) | (dat_i & wmask);
                    `REG_START: sw_start <= 1'b1; // [R19]
                    default:    sw_start <= 1'b0;
                endcase
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state    <= ST_IDLE;
            chan     <= 4'h0;
            conv_cnt <= 16'h0000;
            gap_cnt  <= 16'h0000;
            ext_d    <= 1'b0;
            overrun  <= 1'b0;
        end else begin
            state <= next_state;
            chan  <= next_chan;
            ext_d <= ext_s;
            // Set wins over the clear so an overrun is never lost.
            if (trig && state != ST_IDLE)
                overrun <= 1'b1; // [R21]
            else if (wr && adr_i == `REG_STATUS)
                overrun <= 1'b0;
            if (state == ST_CONV)
                conv_cnt <= conv_end ? 16'h0000 : conv_cnt + 16'h0001;
            else
                conv_cnt <= 16'h0000;
            // Spacing runs from each conversion start.
            if (next_state == ST_CONV && state != ST_CONV)
                gap_cnt <= 16'h0000;
            else if (!gap_end)
                gap_cnt <= gap_cnt + 16'h0001;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            adc_convert_o  <= 1'b0;
            mux_chan_o     <= 4'h0;
            gain_o         <= 2'h0;
            exp_sel_o      <= 4'h0;
            result_o       <= 16'h0000;
            result_chan_o  <= 4'h0;
            result_valid_o <= 1'b0;
            pacer_event_o  <= 1'b0;
        end else begin
            adc_convert_o <= (next_state == ST_CONV); // [R21]
            mux_chan_o    <= next_chan & ch_mask; // [R1]
            gain_o        <= scan[`SCAN_GAIN_HI:`SCAN_GAIN_LO]; // [R13]
            exp_sel_o     <= dout[3:0]; // [R4]
            result_valid_o <= conv_end; // [R22]
            if (conv_end) begin
                result_o      <= {adc_s, 4'h0}; // [R3]
                result_chan_o <= chan; // [R22]
            end
            pacer_event_o <= pacer_tick &&
                             !(enabled && src == `SRC_INT); // [R18]
        end
    end
endmodule

/* rtl/pacer_counters.v */
// Internal pacer: timebase prescaler and two cascaded down counters.
`timescale 1ns/1ps
`include "scan_pacer_defines.vh"
module pacer_counters (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        tb_10mhz_i,
    input  wire [15:0] div1_i,
    input  wire [15:0] div2_i,
    output reg         tick_o
);
    reg  [5:0]  pre;
    reg  [15:0] cnt1;
    reg  [15:0] cnt2;
    wire [5:0]  pre_top;
    wire [15:0] top1;
    wire [15:0] top2;
    wire        tb_tick;
    wire        c1_tick;

    // A divisor below two would stall the cascade, so it is raised to two.
    assign pre_top = tb_10mhz_i ? `TB_10MHZ_TOP : `TB_1MHZ_TOP;
    assign top1    = (div1_i < 16'h0002) ? 16'h0001 : div1_i - 16'h0001;
    assign top2    = (div2_i < 16'h0002) ? 16'h0001 : div2_i - 16'h0001;
    assign tb_tick = (pre == 6'h00);
    assign c1_tick = tb_tick && (cnt1 == 16'h0000);

    always @(posedge clk_i) begin
        if (rst_i) begin
            pre    <= 6'h00;
            cnt1   <= 16'h0000;
            cnt2   <= 16'h0000;
            tick_o <= 1'b0;
        end else begin
            pre    <= tb_tick ? pre_top : pre - 6'h01; // [R14]
            tick_o <= 1'b0;
            if (tb_tick)
                cnt1 <= (cnt1 == 16'h0000) ? top1 : cnt1 - 16'h0001;
            if (c1_tick) begin
                cnt2 <= (cnt2 == 16'h0000) ? top2 : cnt2 - 16'h0001;
                tick_o <= (cnt2 == 16'h0000); // [R14]
            end
        end
    end
endmodule

/* rtl/sync2.v */
// Two flip-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
module sync2 #(
    parameter W = 1
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta;

    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= {W{1'b0}};
            q_o  <= {W{1'b0}};
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule

/* verif/analog_input_scan_pacer_bench.sv */
// Self-checking bench for the analog input scan pacer.
`timescale 1ns/1ps
`include "scan_pacer_defines.vh"
module analog_input_scan_pacer_bench;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack;
    logic diff = 0, pace = 0, ext, conv, valid, pev;
    logic [2:0] adr = 3'h0;
    logic [31:0] dat = 32'h0, dout, q;
    logic [11:0] code = 12'h0, adc;
    logic [15:0] res, lfsr = 16'h0010;
    logic [3:0] mux, rch, esel;
    logic [1:0] gain;
    logic [19:0] exp_q[$];
    logic [19:0] e;
    integer error_cnt = 0, check_count = 0, cyc_no = 0, last_t = 0, gap = 0;

    analog_input_scan_pacer dut (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf),
        .dat_i(dat), .dat_o(dout), .ack_o(ack), .diff_mode_i(diff),
        .tb_10mhz_i(1'b1), .ext_pacer_gate_input_i(ext), .adc_data_i(adc),
        .adc_convert_o(conv), .mux_chan_o(mux), .gain_o(gain),
        .exp_sel_o(esel), .result_o(res), .result_chan_o(rch),
        .result_valid_o(valid), .pacer_event_o(pev));
    front_end_model fe (.adc_convert_i(conv), .code_i(code), .pace_i(pace),
        .adc_data_o(adc), .ext_clk_o(ext));

    initial forever #12.5 clk_i = ~clk_i;

    function logic [15:0] lfsr_next(input logic [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task chk(input string name, input logic [31:0] ex, input logic [31:0] got);
        check_count++;
        if (got !== ex) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, ex, got);
        end
    endtask

    task wb(input logic w, input logic [2:0] a, input logic [31:0] d);
        integer n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 100);
        if (n >= 100) chk("bus ack", 1, 0);
        q = dout;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task rd_chk(input string name, input logic [2:0] a, input logic [31:0] ex);
        wb(1'b0, a, 32'h0);
        chk(name, ex, q);
    endtask

    task expect_conv(input logic [3:0] ch);
        exp_q.push_back({ch, code, 4'h0});
    endtask

    task wait_empty;
        integer n;
        n = 0;
        while (exp_q.size() != 0 && n < 30000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 30000) chk("result wait", 1, 0);
    endtask

    task do_reset;
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task wrap_up;
        if (error_cnt == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Each result strobe takes the oldest expected result off the queue; a strobe with the queue empty is an error.
    always @(posedge clk_i) begin
        cyc_no <= cyc_no + 1;
        if (valid === 1'b1) begin
            gap = cyc_no - last_t;
            last_t = cyc_no;
            if (exp_q.size() == 0) begin
                chk("unexpected result", 0, 1);
            end else begin
                e = exp_q.pop_front();
                chk("result", {12'h0, e}, {12'h0, rch, res});
            end
        end
    end

    initial begin
        #2000000;
        chk("watchdog", 1, 0);
        wrap_up();
    end

    initial begin
        integer g, n;
        do_reset();
        rd_chk("ctrl reset", `REG_CTRL, `CTRL_RST);
        rd_chk("burst reset", `REG_BURST, `BURST_RST);
        rd_chk("pacer reset", `REG_PACER, `PACER_RST);
        n = 0;
        while (pev !== 1'b1 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        chk("pacer event", 1, pev);
        wb(1'b1, `REG_CTRL, 32'h10);
        for (g = 0; g < 5; g++) begin
            lfsr = lfsr_next(lfsr);
            code = lfsr[11:0];
            wb(1'b1, `REG_SCAN, {22'h0, g[1:0], 8'h30});
            expect_conv(g[3:0] % 4);
            wb(1'b1, `REG_START, 32'h0);
            wait_empty();
            chk("gain", g % 4, gain);
        end
        expect_conv(4'h1);
        wb(1'b1, `REG_START, 32'h0);
        wb(1'b1, `REG_START, 32'h0);
        wait_empty();
        repeat (450) @(posedge clk_i);
        wb(1'b0, `REG_STATUS, 32'h0);
        chk("overrun flag", 1, q[7]);
        chk("busy flag", 0, q[6]);
        lfsr = lfsr_next(lfsr);
        wb(1'b1, `REG_DOUT, {28'h0, lfsr[3:0]});
        @(negedge clk_i);
        chk("expansion select", lfsr[3:0], esel);
        do_reset();
        diff <= 1'b1;
        wb(1'b1, `REG_SCAN, 32'h10);
        wb(1'b1, `REG_CTRL, 32'h12);
        expect_conv(4'h0);
        expect_conv(4'h1);
        expect_conv(4'h0);
        pace <= 1'b1;
        wait_empty();
        pace <= 1'b0;
        do_reset();
        diff <= 1'b0;
        wb(1'b1, `REG_PACER, {16'd20, 16'd100});
        wb(1'b1, `REG_BURST, 32'h258);
        wb(1'b1, `REG_SCAN, 32'h20);
        for (g = 0; g < 3; g++) expect_conv(g[3:0]);
        wb(1'b1, `REG_CTRL, 32'h15);
        wait_empty();
        wb(1'b1, `REG_CTRL, 32'h0);
        chk("burst spacing", 600, gap);
        wrap_up();
    end
endmodule

/* verif/front_end_model.sv */
// Model of the analog front end and of an external pacer clock source.
`timescale 1ns/1ps
module front_end_model (
    input  logic        adc_convert_i,
    input  logic [11:0] code_i,
    input  logic        pace_i,
    output logic [11:0] adc_data_o,
    output logic        ext_clk_o
);
    // Outside a conversion the code is inverted so a stale value never
    // passes for a fresh sample.
    assign adc_data_o = adc_convert_i ? code_i : ~code_i;

    // A 40 kHz clock stays well under the converter maximum; the pin idles
    // high as a pulled-up input does.
    initial begin
        ext_clk_o = 1'b1;
        forever begin
            if (pace_i) begin
                ext_clk_o = 1'b0;
                #12500;
                ext_clk_o = 1'b1;
                #12500;
            end else
                #25;
        end
    end
endmodule

/* verif/scan_pacer_monitor.sv */
// Concurrent checks on the conversion outputs of the scan pacer.
`timescale 1ns/1ps
module scan_pacer_monitor (
    input logic        clk_i,
    input logic        rst_i,
    input logic        diff_mode_i,
    input logic        adc_convert_o,
    input logic [3:0]  mux_chan_o,
    input logic [1:0]  gain_o,
    input logic [15:0] result_o,
    input logic [3:0]  result_chan_o,
    input logic        result_valid_o,
    input logic        pacer_event_o
);
    logic [9:0] conv_cnt;

    // Counts the cycles the convert strobe has been high so far.
    always @(posedge clk_i) begin
        if (rst_i || !adc_convert_o)
            conv_cnt <= 10'h000;
        else
            conv_cnt <= conv_cnt + 10'h001;
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence conv_done;
        $fell(adc_convert_o);
    endsequence

    sequence diff_held;
        diff_mode_i[*8];
    endsequence

    a_conv_length: assert property (conv_done |-> conv_cnt == 10'd400)
        else $error("conversion strobe not 400 cycles long");
    a_no_overlap: assert property (adc_convert_o |-> conv_cnt < 10'd400)
        else $error("conversion strobe stretched past one conversion");
    a_result_end: assert property (conv_done |-> result_valid_o
        && result_chan_o == $past(mux_chan_o))
        else $error("result missing or wrong channel at conversion end");
    a_result_alone: assert property (result_valid_o
        |-> conv_done ##1 !result_valid_o)
        else $error("result strobe not a single end-of-conversion pulse");
    a_left_just: assert property (result_valid_o |-> result_o[3:0] == 4'h0)
        else $error("result not left-justified");
    a_mux_steady: assert property (adc_convert_o && $past(adc_convert_o)
        |-> $stable(mux_chan_o) && $stable(gain_o))
        else $error("channel or gain moved during conversion");
    a_diff_range: assert property (diff_held ##0 adc_convert_o
        |-> mux_chan_o[3] == 1'b0)
        else $error("channel above seven in differential mode");
    a_pacer_pulse: assert property (pacer_event_o |=> !pacer_event_o)
        else $error("pacer event longer than one cycle");
endmodule

bind analog_input_scan_pacer scan_pacer_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .diff_mode_i(diff_mode_i),
    .adc_convert_o(adc_convert_o), .mux_chan_o(mux_chan_o),
    .gain_o(gain_o), .result_o(result_o), .result_chan_o(result_chan_o),
    .result_valid_o(result_valid_o), .pacer_event_o(pacer_event_o)
);
